// ### hw/lefs_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the load encoder feedback scaling block
// Assumes: Word-aligned register map on a plain strobe port
// Notes:   Definitions only
`ifndef LEFS_CONSTS_SVH
`define LEFS_CONSTS_SVH

`define LEFS_ADDR_W          8
`define LEFS_OFS_CTRL        8'h00
`define LEFS_OFS_GEAR_NUM    8'h04
`define LEFS_OFS_GEAR_DEN    8'h08
`define LEFS_OFS_MOTOR_PPR   8'h0C
`define LEFS_OFS_ERR_LIMIT   8'h10
`define LEFS_OFS_STATUS      8'h14
`define LEFS_OFS_MASK        8'h18
`define LEFS_OFS_ALARM       8'h1C
`define LEFS_OFS_LOAD_CUM    8'h20
`define LEFS_OFS_MOTOR_RAW   8'h24
`define LEFS_OFS_MOTOR_GEAR  8'h28
`define LEFS_OFS_LOAD_INFO1  8'h2C

`define LEFS_CTRL_LOAD_POL   0
`define LEFS_CTRL_MOTOR_DIR  1
`define LEFS_ST_PARAM_ERR    0
`define LEFS_ST_LOOP_ERR     1
`define LEFS_ST_REF_MARK     2
`define LEFS_ST_W            3

`define LEFS_RST_GEAR_NUM    32'h0001_0001
`define LEFS_RST_GEAR_DEN    32'h0001_0001
`define LEFS_RST_MOTOR_PPR   32'h0004_0000
`define LEFS_RST_ERR_LIMIT   32'h0000_1000

`define LEFS_ALARM_NONE      8'h00
`define LEFS_ALARM_PARAM     8'h25
`define LEFS_ALARM_LOOP      8'h2A

`define LEFS_LOAD_PPR_MIN    64'h0000_0000_0000_1000
`define LEFS_LOAD_PPR_MAX    64'h0000_0000_0400_0000

`endif

// ### hw/lefs_gear.sv
// Purpose: Fractional electronic gear from motor steps to load-side units
// Assumes: Motor steps arrive far slower than clk when the ratio exceeds one
// Notes:   At most one geared step per cycle; the remainder absorbs any backlog
`timescale 1ns/1ps
`default_nettype none
module lefs_gear
  import lefs_pkg::*;
#(
  parameter int REM_W = 40
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire lefs_step_s  motor,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  output lefs_step_s       geared
);

  logic signed [REM_W-1:0] rem;
  logic signed [REM_W-1:0] tmp;
  logic signed [REM_W-1:0] num_s;
  logic signed [REM_W-1:0] den_s;

  assign num_s = REM_W'(num);
  assign den_s = REM_W'(den);

  always_comb begin
    tmp = rem;
    if (motor.step) begin
      tmp = motor.up ? rem + num_s : rem - num_s;
    end
  end

  // Exact remainder kept between steps, so no rounding drift builds up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem    <= '0;
      geared <= '0;
    end else if (!enable) begin
      geared <= '0;
    end else if (tmp >= den_s) begin
      rem    <= tmp - den_s;
      geared <= '{step: 1'b1, up: 1'b1};
    end else if (tmp < 0) begin
      rem    <= tmp + den_s;
      geared <= '{step: 1'b1, up: 1'b0};
    end else begin
      rem    <= tmp;
      geared <= '0;
    end
  end

  gear_remainder_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && motor.step && motor.up && rem >= 0 && (rem + num_s) < den_s)
      |=> (rem == $past(rem) + $past(num_s) && !geared.step))
    else $error("gear remainder not carried");

endmodule
`default_nettype wire

// ### hw/lefs_pkg.sv
// Purpose: Types shared by the load encoder feedback scaling block
// Assumes: Nothing beyond the constants header
// Notes:   Structs only
package lefs_pkg;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } lefs_enc_s;

  typedef struct packed {
    logic step;
    logic up;
  } lefs_step_s;

  typedef struct packed {
    logic [15:0] num_b;
    logic [15:0] num_a;
    logic [15:0] den_b;
    logic [15:0] den_a;
  } lefs_gear_cfg_s;

endpackage

// ### hw/lefs_quad_decoder.sv
// Purpose: Quadrature decoder for the load-side encoder, four counts per line cycle
// Assumes: A, B and Z already synchronous to clk
// Notes:   First sample after reset only primes the history
`timescale 1ns/1ps
`default_nettype none
module lefs_quad_decoder
  import lefs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire lefs_enc_s  enc,
  input  wire logic       polarity,
  output lefs_step_s      step,
  output logic            ref_mark
);

  logic a_q;
  logic b_q;
  logic z_q;
  logic primed;
  logic moved;
  logic fwd;

  // Exactly one phase changed is a legal edge; both at once is dropped
  assign moved = (enc.a ^ a_q) ^ (enc.b ^ b_q);
  assign fwd   = enc.a ^ b_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q    <= 1'b0;
      b_q    <= 1'b0;
      z_q    <= 1'b0;
      primed <= 1'b0;
    end else begin
      a_q    <= enc.a;
      b_q    <= enc.b;
      z_q    <= enc.z;
      primed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step     <= '0;
      ref_mark <= 1'b0;
    end else begin
      step.step <= primed & moved;
      step.up   <= fwd ^ polarity;
      ref_mark  <= primed & enc.z & ~z_q;
    end
  end

  polarity_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    (primed && moved) |=> (step.step && step.up == ($past(fwd) ^ $past(polarity))))
    else $error("load step direction ignores polarity");

endmodule
`default_nettype wire

// ### hw/lefs_top.sv
// Purpose: Load-side encoder feedback, feedback gear, cumulative counts and closed-loop checks
// Assumes: Encoder and motor step inputs synchronous to clk; registers on a plain strobe port
// Notes:   Counts wrap at CNT_W bits; mismatch check uses the wrapped difference
`timescale 1ns/1ps
`default_nettype none
`include "lefs_consts.svh"
module lefs_top
  import lefs_pkg::*;
#(
  parameter int CNT_W = 32
)(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [`LEFS_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [31:0]                  rdata,
  input  wire lefs_enc_s               load_enc,
  input  wire lefs_step_s              motor_fb,
  input  wire logic                    positioning,
  input  wire logic                    cmd_dir,
  output logic                         motor_cmd_dir,
  output logic [7:0]                   alarm_code,
  output logic                         irq
);

  logic                    load_pol;
  logic                    motor_rot_sel;
  lefs_gear_cfg_s          gear_cfg;
  logic [31:0]             motor_ppr;
  logic [31:0]             err_limit;
  logic [`LEFS_ST_W-1:0]   status;
  logic [`LEFS_ST_W-1:0]   mask;
  logic [`LEFS_ST_W-1:0]   events;
  logic [`LEFS_ST_W-1:0]   w1c;
  logic [CNT_W-1:0]        load_cum;
  logic [CNT_W-1:0]        load_info1;
  logic [CNT_W-1:0]        motor_raw;
  logic [CNT_W-1:0]        motor_geared;
  logic [CNT_W-1:0]        cnt_diff;
  logic [CNT_W-1:0]        abs_diff;
  logic [31:0]             gear_num;
  logic [31:0]             gear_den;
  logic [63:0]             load_ppr_scaled;
  logic [63:0]             den_wide;
  logic                    param_invalid;
  logic                    loop_mismatch;
  lefs_step_s              load_step;
  lefs_step_s              geared_step;
  logic                    ref_mark;
  logic                    wr_ctrl;
  logic [31:0]             next_rdata;

  // Load-side decoder: polarity applies here and nowhere else
  lefs_quad_decoder u_decoder (
    .clk      (clk),
    .rst_n    (rst_n),
    .enc      (load_enc),
    .polarity (load_pol),
    .step     (load_step),
    .ref_mark (ref_mark)
  );

  // Gear products; each factor is 16 bits so the products fit 32
  assign gear_num = 32'(gear_cfg.num_a) * 32'(gear_cfg.num_b);
  assign gear_den = 32'(gear_cfg.den_a) * 32'(gear_cfg.den_b);

  lefs_gear u_gear (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (~param_invalid),
    .motor  (motor_fb),
    .num    (gear_num),
    .den    (gear_den),
    .geared (geared_step)
  );

  // Load pulses per motor rev = motor_ppr * num / den, checked against den-scaled bounds
  assign load_ppr_scaled = 64'(motor_ppr) * 64'(gear_num);
  assign den_wide        = 64'(gear_den);

  always_comb begin
    param_invalid = 1'b0;
    if (gear_num == 32'h0000_0000 || gear_den == 32'h0000_0000) begin
      param_invalid = 1'b1;
    end else if (load_ppr_scaled < (den_wide * `LEFS_LOAD_PPR_MIN)) begin
      param_invalid = 1'b1;
    end else if (load_ppr_scaled > (den_wide * `LEFS_LOAD_PPR_MAX)) begin
      param_invalid = 1'b1;
    end
  end

  // Signed difference of wrapped counts, so wrap-around is harmless
  assign cnt_diff      = motor_geared - load_cum;
  assign abs_diff      = cnt_diff[CNT_W-1] ? CNT_W'(-cnt_diff) : cnt_diff;
  assign loop_mismatch = positioning & ~param_invalid & (32'(abs_diff) > err_limit);

  assign events[`LEFS_ST_PARAM_ERR] = param_invalid;
  assign events[`LEFS_ST_LOOP_ERR]  = loop_mismatch;
  assign events[`LEFS_ST_REF_MARK]  = ref_mark;

  assign wr_ctrl = wr_en & (addr == `LEFS_OFS_CTRL);
  assign w1c     = (wr_en && addr == `LEFS_OFS_STATUS) ? wdata[`LEFS_ST_W-1:0] : '0;

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pol      <= 1'b0;
      motor_rot_sel <= 1'b0;
    end else if (wr_ctrl) begin
      load_pol      <= wdata[`LEFS_CTRL_LOAD_POL];
      motor_rot_sel <= wdata[`LEFS_CTRL_MOTOR_DIR];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gear_cfg  <= {`LEFS_RST_GEAR_NUM, `LEFS_RST_GEAR_DEN};
      motor_ppr <= `LEFS_RST_MOTOR_PPR;
      err_limit <= `LEFS_RST_ERR_LIMIT;
      mask      <= '0;
    end else if (wr_en) begin
      unique case (addr)
        `LEFS_OFS_GEAR_NUM:  gear_cfg[63:32] <= wdata;
        `LEFS_OFS_GEAR_DEN:  gear_cfg[31:0]  <= wdata;
        `LEFS_OFS_MOTOR_PPR: motor_ppr       <= wdata;
        `LEFS_OFS_ERR_LIMIT: err_limit       <= wdata;
        `LEFS_OFS_MASK:      mask            <= wdata[`LEFS_ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status: a new event outranks a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~w1c) | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status & ~w1c | events) & mask);
    end
  end

  // Parameter alarm takes precedence over the closed-loop alarm
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_code <= `LEFS_ALARM_NONE;
    end else if (param_invalid) begin
      alarm_code <= `LEFS_ALARM_PARAM;
    end else if (loop_mismatch || status[`LEFS_ST_LOOP_ERR]) begin
      alarm_code <= `LEFS_ALARM_LOOP;
    end else begin
      alarm_code <= `LEFS_ALARM_NONE;
    end
  end

  // Motor rotation direction only flips the command, never the feedback counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_cmd_dir <= 1'b0;
    end else begin
      motor_cmd_dir <= cmd_dir ^ motor_rot_sel;
    end
  end

  // Cumulative counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_cum <= '0;
    end else if (load_step.step) begin
      load_cum <= load_step.up ? load_cum + 1'b1 : load_cum - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_info1 <= '0;
    end else if (ref_mark) begin
      load_info1 <= '0;
    end else if (load_step.step) begin
      load_info1 <= load_step.up ? load_info1 + 1'b1 : load_info1 - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_raw <= '0;
    end else if (motor_fb.step) begin
      motor_raw <= motor_fb.up ? motor_raw + 1'b1 : motor_raw - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_geared <= '0;
    end else if (geared_step.step) begin
      motor_geared <= geared_step.up ? motor_geared + 1'b1 : motor_geared - 1'b1;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      `LEFS_OFS_CTRL:       next_rdata = {30'h0, motor_rot_sel, load_pol};
      `LEFS_OFS_GEAR_NUM:   next_rdata = gear_cfg[63:32];
      `LEFS_OFS_GEAR_DEN:   next_rdata = gear_cfg[31:0];
      `LEFS_OFS_MOTOR_PPR:  next_rdata = motor_ppr;
      `LEFS_OFS_ERR_LIMIT:  next_rdata = err_limit;
      `LEFS_OFS_STATUS:     next_rdata = 32'(status);
      `LEFS_OFS_MASK:       next_rdata = 32'(mask);
      `LEFS_OFS_ALARM:      next_rdata = 32'(alarm_code);
      `LEFS_OFS_LOAD_CUM:   next_rdata = 32'(load_cum);
      `LEFS_OFS_MOTOR_RAW:  next_rdata = 32'(motor_raw);
      `LEFS_OFS_MOTOR_GEAR: next_rdata = 32'(motor_geared);
      `LEFS_OFS_LOAD_INFO1: next_rdata = 32'(load_info1);
      default:              next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd_en ? next_rdata : 32'h0000_0000;
    end
  end

  param_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    param_invalid |=> (alarm_code == `LEFS_ALARM_PARAM && status[`LEFS_ST_PARAM_ERR]))
    else $error("parameter alarm not raised");

  gear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (gear_cfg.den_a == 16'h0000) |-> param_invalid)
    else $error("zero denominator accepted");

  ppr_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (gear_num == gear_den && gear_num != 32'h0 && motor_ppr > `LEFS_LOAD_PPR_MAX) |-> param_invalid)
    else $error("load pulses per rev above range accepted");

  loop_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    (loop_mismatch ##1 !param_invalid) |-> (status[`LEFS_ST_LOOP_ERR] && alarm_code == `LEFS_ALARM_LOOP))
    else $error("closed loop alarm not raised");

  no_idle_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!positioning && !status[`LEFS_ST_LOOP_ERR]) |=> !status[`LEFS_ST_LOOP_ERR])
    else $error("closed loop alarm outside positioning");

  load_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    load_step.step |=> (load_cum == ($past(load_step.up) ? $past(load_cum) + 1'b1 : $past(load_cum) - 1'b1)))
    else $error("load cumulative count wrong");

  ref_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ref_mark |=> (load_info1 == '0 && status[`LEFS_ST_REF_MARK]))
    else $error("load information one not cleared");

  raw_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!motor_fb.step) |=> (motor_raw == $past(motor_raw)))
    else $error("raw motor count moved without a step");

  cmd_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(motor_rot_sel) && !wr_ctrl) |=> (load_pol == $past(load_pol) &&
      motor_cmd_dir == ($past(cmd_dir) ^ $past(motor_rot_sel))))
    else $error("rotation direction disturbed polarity");

  unity_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    (gear_num == gear_den && !param_invalid && motor_fb.step && motor_fb.up) |=> geared_step.step)
    else $error("unity gear did not track motor step");

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ref_mark && w1c[`LEFS_ST_REF_MARK]) |=> status[`LEFS_ST_REF_MARK])
    else $error("event lost to simultaneous clear");

  // Bus, status, alarm, gear and counter checks, all in the single clk domain
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_en |=> (rdata == 32'h0000_0000))
    else $error("read data outside the read cycle");

  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mask == '0) |=> !irq)
    else $error("interrupt with every source masked");

  status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (w1c[`LEFS_ST_REF_MARK] && !ref_mark) |=> !status[`LEFS_ST_REF_MARK])
    else $error("status bit survived its clear");

  ref_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (status[`LEFS_ST_REF_MARK] && !w1c[`LEFS_ST_REF_MARK]) |=> status[`LEFS_ST_REF_MARK])
    else $error("sticky status bit dropped");

  alarm_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!param_invalid && !loop_mismatch && !status[`LEFS_ST_LOOP_ERR]) |=> (alarm_code == `LEFS_ALARM_NONE))
    else $error("alarm without a cause");

  loop_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    param_invalid |-> !loop_mismatch)
    else $error("closed loop check ran on invalid gear");

  gear_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
    param_invalid |=> !geared_step.step)
    else $error("gear stepped with invalid settings");

  raw_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    motor_fb.step |=> (motor_raw == ($past(motor_fb.up) ? $past(motor_raw) + 1'b1 : $past(motor_raw) - 1'b1)))
    else $error("raw motor count missed a step");

  info_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (load_step.step && !ref_mark) |=>
      (load_info1 == ($past(load_step.up) ? $past(load_info1) + 1'b1 : $past(load_info1) - 1'b1)))
    else $error("load information one count wrong");

  geared_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    geared_step.step |=>
      (motor_geared == ($past(geared_step.up) ? $past(motor_geared) + 1'b1 : $past(motor_geared) - 1'b1)))
    else $error("geared motor count wrong");

  load_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!load_step.step) |=> (load_cum == $past(load_cum)))
    else $error("load count moved without a step");

endmodule
`default_nettype wire

// ### sim/lefs_enc_model.sv
// Purpose: Load-side quadrature encoder seen from the block's encoder pins
// Assumes: One count per step request, reference mark on request
// Notes:   Phases are plain levels that stay driven; the encoder never releases them
`timescale 1ns/1ps
`default_nettype none
module lefs_enc_model
  import lefs_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire logic    step,
  input  wire logic    fwd,
  input  wire logic    z_req,
  output var lefs_enc_s enc
);
  logic [1:0] phase;
  logic       z_q;

  // Four states per line cycle, A leads B going forward
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      z_q   <= 1'b0;
    end else begin
      if (step) begin
        phase <= fwd ? phase + 2'h1 : phase - 2'h1;
      end
      z_q <= z_req;
    end
  end

  always_comb begin
    enc.a = phase[0] ^ phase[1];
    enc.b = phase[1];
    enc.z = z_q;
  end
endmodule
`default_nettype wire

// ### sim/lefs_top_bench.sv
// Purpose: Self-checking bench for the load encoder feedback scaling block
// Assumes: Read data compared one cycle after the read strobe
// Notes:   Counts are tracked in bench variables, never taken from the design
`timescale 1ns/1ps
`default_nettype none
`include "lefs_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module lefs_top_bench
  import lefs_pkg::*;
;
  logic        clk, rst_n, wr_en, rd_en, positioning, cmd_dir, motor_cmd_dir, irq, rd_d, u;
  logic        enc_step, enc_fwd, enc_z;
  logic [7:0]  addr, alarm_code;
  logic [31:0] wdata, rdata, exp_v;
  lefs_enc_s   load_enc;
  lefs_step_s  motor_fb;
  int          err_count = 0, comparisons = 0, cyc = 0, seed, lc, mr, mg, net, k;
  longint      p, q;
  logic [31:0] exp_q[$];
  logic [31:0] tn[5] = '{32'h0001_0000, 32'h0001_0001, 32'h0001_0101, 32'h0001_0100, 32'h0001_0001};
  logic [31:0] td[5] = '{32'h0001_0001, 32'h0001_0064, 32'h0001_0001, 32'h0001_0001, 32'h0001_0040};
  logic [4:0]  tbad  = 5'b00111;

  lefs_top #(.CNT_W(32)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .load_enc(load_enc), .motor_fb(motor_fb), .positioning(positioning),
    .cmd_dir(cmd_dir), .motor_cmd_dir(motor_cmd_dir), .alarm_code(alarm_code), .irq(irq));
  lefs_enc_model u_enc (.clk(clk), .rst_n(rst_n), .step(enc_step), .fwd(enc_fwd), .z_req(enc_z),
    .enc(load_enc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // A one-cycle gap after each strobe keeps a strobe from being written twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic enc_move(input int n, input logic f);
    repeat (n) begin
      enc_step <= 1'b1; enc_fwd <= f;
      @(posedge clk);
      enc_step <= 1'b0;
      @(posedge clk);
    end
    idle(4);
  endtask

  task automatic mot_move(input int n, input logic up);
    repeat (n) begin
      motor_fb <= '{step: 1'b1, up: up};
      @(posedge clk);
      motor_fb.step <= 1'b0;
      @(posedge clk);
    end
    idle(4);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that edge
  always @(posedge clk) begin
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
    rd_d <= rd_en;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    seed = 54; rst_n = 1'b0; rd_d = 1'b0; lc = 0; mr = 0; mg = 0;
    {wr_en, rd_en, positioning, cmd_dir, enc_step, enc_fwd, enc_z} = '0;
    addr = '0; wdata = '0; motor_fb = '0;
    idle(16);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`LEFS_OFS_GEAR_NUM, `LEFS_RST_GEAR_NUM);
    rd(`LEFS_OFS_GEAR_DEN, `LEFS_RST_GEAR_DEN);
    rd(`LEFS_OFS_MOTOR_PPR, `LEFS_RST_MOTOR_PPR);
    rd(`LEFS_OFS_ERR_LIMIT, `LEFS_RST_ERR_LIMIT);
    rd(`LEFS_OFS_MASK, 32'h0);
    rd(8'h30, 32'h0);
    wr(`LEFS_OFS_LOAD_CUM, 32'h55);
    rd(`LEFS_OFS_LOAD_CUM, 32'h0);
    enc_move(20, 1'b1);
    rd(`LEFS_OFS_LOAD_CUM, 32'h14);
    enc_move(8, 1'b0);
    rd(`LEFS_OFS_LOAD_CUM, 32'h0C);
    wr(`LEFS_OFS_CTRL, 32'h1);
    enc_move(12, 1'b1);
    rd(`LEFS_OFS_LOAD_CUM, 32'h0);
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 2; d++) begin
        wr(`LEFS_OFS_CTRL, 32'(c));
        cmd_dir <= d[0];
        idle(2);
        `CHK(motor_cmd_dir, d[0] ^ c[1])
      end
    end
    enc_move(4, 1'b1);
    lc = -4;
    rd(`LEFS_OFS_LOAD_CUM, 32'(lc));
    rd(`LEFS_OFS_LOAD_INFO1, 32'(lc));
    wr(`LEFS_OFS_MASK, 32'h4);
    enc_z <= 1'b1;
    @(posedge clk);
    enc_z <= 1'b0;
    @(posedge clk);
    // The clear lands in the very cycle the mark is flagged, so the flag must stay
    wr(`LEFS_OFS_STATUS, 32'h4);
    idle(2);
    rd(`LEFS_OFS_LOAD_INFO1, 32'h0);
    rd(`LEFS_OFS_LOAD_CUM, 32'(lc));
    rd(`LEFS_OFS_STATUS, 32'h4);
    `CHK(irq, 1'b1)
    wr(`LEFS_OFS_MASK, 32'h0);
    idle(1);
    `CHK(irq, 1'b0)
    wr(`LEFS_OFS_MASK, 32'h3);
    wr(`LEFS_OFS_STATUS, 32'h4);
    rd(`LEFS_OFS_STATUS, 32'h0);
    wr(`LEFS_OFS_CTRL, 32'h0);
    enc_move(4, 1'b1);
    lc = 0;
    rd(`LEFS_OFS_LOAD_INFO1, 32'h4);
    mot_move(4, 1'b1);
    rd(`LEFS_OFS_MOTOR_RAW, 32'h4);
    rd(`LEFS_OFS_MOTOR_GEAR, 32'h4);
    wr(`LEFS_OFS_ERR_LIMIT, 32'h3);
    positioning <= 1'b1;
    mot_move(5, 1'b1);
    `CHK(alarm_code, `LEFS_ALARM_LOOP)
    `CHK(irq, 1'b1)
    rd(`LEFS_OFS_STATUS, 32'h2);
    positioning <= 1'b0;
    wr(`LEFS_OFS_STATUS, 32'h2);
    idle(1);
    `CHK(alarm_code, `LEFS_ALARM_NONE)
    `CHK(irq, 1'b0)
    wr(`LEFS_OFS_GEAR_NUM, 32'h0001_0000);
    positioning <= 1'b1;
    idle(3);
    `CHK(alarm_code, `LEFS_ALARM_PARAM)
    rd(`LEFS_OFS_STATUS, 32'h1);
    mot_move(2, 1'b1);
    positioning <= 1'b0;
    rd(`LEFS_OFS_MOTOR_RAW, 32'hB);
    rd(`LEFS_OFS_MOTOR_GEAR, 32'h9);
    // Rows cover a zero factor, both range limits and both exact boundaries
    for (int i = 0; i < 5; i++) begin
      wr(`LEFS_OFS_GEAR_NUM, tn[i]);
      wr(`LEFS_OFS_GEAR_DEN, td[i]);
      wr(`LEFS_OFS_STATUS, 32'h7);
      idle(1);
      `CHK(alarm_code, tbad[i] ? `LEFS_ALARM_PARAM : `LEFS_ALARM_NONE)
      rd(`LEFS_OFS_STATUS, {31'h0, tbad[i]});
    end
    // Load side of about 36363 counts per motor revolution
    wr(`LEFS_OFS_GEAR_NUM, 32'h0001_0C35);
    wr(`LEFS_OFS_GEAR_DEN, 32'h0001_5800);
    k = 300 + ($unsigned($random(seed)) % 300);
    net = 0;
    repeat (k) begin
      u = $random(seed);
      mot_move(1, u);
      net += u ? 1 : -1;
    end
    p = longint'(net) * 3125;
    q = p / 22528;
    if (p < 0 && q * 22528 != p) q--;
    rd(`LEFS_OFS_MOTOR_RAW, 32'(11 + net));
    rd(`LEFS_OFS_MOTOR_GEAR, 32'(9 + q));
    rd(`LEFS_OFS_LOAD_CUM, 32'(lc));
    // Unity gear with a motor side one pulse too fine for the load range
    wr(`LEFS_OFS_GEAR_NUM, `LEFS_RST_GEAR_NUM);
    wr(`LEFS_OFS_GEAR_DEN, `LEFS_RST_GEAR_DEN);
    wr(`LEFS_OFS_MOTOR_PPR, 32'h0400_0001);
    idle(1);
    `CHK(alarm_code, `LEFS_ALARM_PARAM)
    rd(`LEFS_OFS_MOTOR_PPR, 32'h0400_0001);
    rd(`LEFS_OFS_ALARM, 32'(`LEFS_ALARM_PARAM));
    idle(2);
    close_out();
  end
endmodule
`default_nettype wire
